// file: hdl/mrpp_buf.sv
/*
 * Two-entry first-in first-out buffer with valid and ready on both sides.
 * Assumes both sides run on the same clock; a full buffer drops in_ready_o.
 */
`timescale 1ns/10ps
`default_nettype none

module mrpp_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage for the buffered words.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    // Write and read pointers and the fill level.
    logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rd_reg];

    // Pointer and level update; pointers wrap at the depth.
    always_comb
    begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (push)
        begin
            wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
        end
        if (pop)
        begin
            rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
        end
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    // Registers of the pointers and level.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Word storage needs no reset; it is read only when valid.
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

endmodule // mrpp_buf

`default_nettype wire

// file: hdl/mrpp_pkg.sv
/*
 * Shared constants for the measurement result printer port: port timing,
 * ASCII characters and text fields of a record, judgement codes and states.
 * Assumes a single 250 MHz clock; all times are converted to cycle counts here.
 */
package mrpp_pkg;

    // Core clock rate in MHz.
    localparam int CLK_MHZ = 250;

    // Data setup time before the strobe falls, in ns.
    localparam int SETUP_NS = 500;
    // Width of the low strobe pulse, in ns.
    localparam int STROBE_NS = 1000;
    // Data hold time after the strobe rises, in ns.
    localparam int HOLD_NS = 1000;

    // Least times round up to whole cycles.
    localparam logic [8:0] SETUP_CYC = 9'((SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [8:0] STROBE_CYC = 9'((STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [8:0] HOLD_CYC = 9'((HOLD_NS * CLK_MHZ + 999) / 1000);

    // A value has five BCD digits and one decimal point.
    localparam logic [2:0] VAL_LEN = 3'h6;

    // Single characters.
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_DOT = 8'h2E;

    // Text fields, left aligned, four characters at most.
    localparam logic [31:0] TXT_OHM = 32'h206F_686D;
    localparam logic [31:0] TXT_OF = 32'h4F46_0000;
    localparam logic [31:0] TXT_NG = 32'h4E47_0000;
    localparam logic [31:0] TXT_VSEP = 32'h2C20_0000;
    localparam logic [31:0] TXT_VUNIT = 32'h5600_0000;
    localparam logic [31:0] TXT_JSEP = 32'h2C00_0000;
    localparam logic [31:0] TXT_EOL = 32'h0D0A_0000;
    localparam logic [31:0] TXT_PASS = 32'h5061_7373;
    localparam logic [31:0] TXT_FAIL = 32'h4661_696C;
    localparam logic [31:0] TXT_LO = 32'h4C6F_0000;
    localparam logic [31:0] TXT_IN = 32'h494E_0000;
    localparam logic [31:0] TXT_HI = 32'h4869_0000;

    // Text field lengths.
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_4 = 3'h4;

    // Comparator judgement codes.
    localparam logic [2:0] JDG_PASS = 3'h0;
    localparam logic [2:0] JDG_FAIL = 3'h1;
    localparam logic [2:0] JDG_LO = 3'h2;
    localparam logic [2:0] JDG_IN = 3'h3;
    localparam logic [2:0] JDG_HI = 3'h4;

    // Record formatter states, one per field of the record.
    typedef enum logic [3:0] {
        FS_IDLE, FS_RVAL, FS_UNIT, FS_MARK, FS_VSEP, FS_VVAL,
        FS_VUNIT, FS_JSEP, FS_JUDGE, FS_EOL
    } mrpp_fmt_type;

    // Printer handshake states.
    typedef enum logic [1:0] {
        PS_IDLE, PS_SETUP, PS_STROBE, PS_HOLD
    } mrpp_port_type;

endpackage : mrpp_pkg

// file: hdl/mrpp_top.sv
/*
 * Measurement result printer port: on a falling print trigger, formats one
 * ASCII text record of the measured values and sends it byte by byte over an
 * eight-bit parallel printer port with strobe and busy.
 * Assumes measurement inputs are stable, same-clock instrument signals; the
 * trigger and busy pins are asynchronous and are synchronised here.
 */
// What this block does
// - Falling print trigger starts one record.
// - Send values, then comparator judgement.
// - Only printable ASCII plus CR LF.
// - Setup mode: ignore triggers, abort the record; bytes already buffered still go out.
// - Comparator off: omit the judgement field.
// - Print OF on overflow, NG if abnormal.
// - Eight data lines, strobe out, busy in.
`timescale 1ns/10ps
`default_nettype none

module mrpp_top
    import mrpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic print_trig_n_i,
    input wire logic busy_i,
    input wire logic setup_mode_i,
    input wire logic comp_enable_i,
    input wire logic volt_mode_i,
    input wire logic overflow_i,
    input wire logic abnormal_i,
    input wire logic [19:0] res_bcd_i,
    input wire logic [2:0] res_dp_i,
    input wire logic [19:0] volt_bcd_i,
    input wire logic [2:0] volt_dp_i,
    input wire logic [2:0] judge_i,
    output logic [7:0] data_o,
    output logic strobe_n_o,
    output logic printing_o
);

    // Three-stage synchronisers and the agreed levels of both pins.
    logic [2:0] trig_sync_reg, busy_sync_reg;
    logic trig_level_reg, trig_level_next, busy_level_reg, busy_level_next;
    logic trig_fall;

    // Formatter state and the measurement snapshot taken at the trigger.
    mrpp_fmt_type fmt_reg, fmt_next;
    logic [2:0] idx_reg, idx_next;
    logic [19:0] res_reg, res_next, volt_reg, volt_next;
    logic [2:0] rdp_reg, rdp_next, vdp_reg, vdp_next, jdg_reg, jdg_next;
    logic of_reg, of_next, ng_reg, ng_next, vm_reg, vm_next, ce_reg, ce_next;

    // Byte pushed into the buffer and the buffer's answer.
    logic push_valid, push_ready;
    logic [7:0] push_data;
    logic [31:0] txt;
    logic [2:0] txt_len;
    logic field_num, field_last;

    // Buffer read side and the printer handshake state.
    logic pop_valid, pop_ready;
    logic [7:0] pop_data;
    mrpp_port_type port_reg, port_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [7:0] data_reg, data_next;
    logic strobe_n_reg, strobe_n_next, printing_reg, printing_next;

    // Picks the character of a number at a position, the point included.
    function automatic logic [7:0] num_char(input logic [19:0] bcd, input logic [2:0] dp, input logic [2:0] pos);
        logic [2:0] dig;
        dig = (pos > dp) ? pos - 3'h1 : pos;
        if (pos == dp)
        begin
            num_char = CH_DOT;
        end
        else
        begin
            num_char = CH_ZERO + {4'h0, bcd[19 - 4 * dig -: 4]};
        end
    endfunction

    // Field that follows the present one in a record.
    function automatic mrpp_fmt_type after_field(input mrpp_fmt_type st, input logic vm, input logic ce);
        case (st)
            FS_RVAL, FS_MARK: after_field = vm ? FS_VSEP : (ce ? FS_JSEP : FS_EOL);
            FS_UNIT: after_field = vm ? FS_VSEP : (ce ? FS_JSEP : FS_EOL);
            FS_VSEP: after_field = FS_VVAL;
            FS_VVAL: after_field = FS_VUNIT;
            FS_VUNIT: after_field = ce ? FS_JSEP : FS_EOL;
            FS_JSEP: after_field = FS_JUDGE;
            FS_JUDGE: after_field = FS_EOL;
            default: after_field = FS_IDLE;
        endcase
    endfunction

    // Synchroniser levels: a change counts once stages two and three agree.
    always_comb
    begin
        trig_level_next = trig_level_reg;
        busy_level_next = busy_level_reg;
        if (trig_sync_reg[1] == trig_sync_reg[2])
        begin
            trig_level_next = trig_sync_reg[2];
        end
        if (busy_sync_reg[1] == busy_sync_reg[2])
        begin
            busy_level_next = busy_sync_reg[2];
        end
        trig_fall = trig_level_reg && !trig_level_next;
    end

    // Synchroniser registers; both pins idle high and low respectively.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            trig_sync_reg <= 3'h7;
            busy_sync_reg <= 3'h0;
            trig_level_reg <= 1'b1;
            busy_level_reg <= 1'b0;
        end
        else
        begin
            trig_sync_reg <= {trig_sync_reg[1:0], print_trig_n_i};
            busy_sync_reg <= {busy_sync_reg[1:0], busy_i};
            trig_level_reg <= trig_level_next;
            busy_level_reg <= busy_level_next;
        end
    end

    // Text of each fixed field and its length.
    always_comb
    begin
        txt = TXT_EOL;
        txt_len = LEN_2;
        field_num = 1'b0;
        case (fmt_reg)
            FS_RVAL, FS_VVAL: field_num = 1'b1;
            // The ohm unit follows the resistance value.
            FS_UNIT:
            begin
                txt = TXT_OHM;
                txt_len = LEN_4;
            end
            FS_MARK: txt = ng_reg ? TXT_NG : TXT_OF;
            FS_VSEP: txt = TXT_VSEP;
            FS_VUNIT:
            begin
                txt = TXT_VUNIT;
                txt_len = LEN_1;
            end
            FS_JSEP:
            begin
                txt = TXT_JSEP;
                txt_len = LEN_1;
            end
            FS_JUDGE:
            begin
                txt_len = LEN_2;
                case (jdg_reg)
                    JDG_PASS:
                    begin
                        txt = TXT_PASS;
                        txt_len = LEN_4;
                    end
                    JDG_FAIL:
                    begin
                        txt = TXT_FAIL;
                        txt_len = LEN_4;
                    end
                    JDG_LO: txt = TXT_LO;
                    JDG_IN: txt = TXT_IN;
                    default: txt = TXT_HI;
                endcase
            end
            default: txt = TXT_EOL;
        endcase
    end

    // Record formatter: walks the fields and pushes one byte per accepted cycle.
    always_comb
    begin
        fmt_next = fmt_reg;
        idx_next = idx_reg;
        res_next = res_reg;
        volt_next = volt_reg;
        rdp_next = rdp_reg;
        vdp_next = vdp_reg;
        jdg_next = jdg_reg;
        of_next = of_reg;
        ng_next = ng_reg;
        vm_next = vm_reg;
        ce_next = ce_reg;
        push_valid = 1'b0;
        // Bytes come only from ASCII digits, text and CR LF.
        push_data = (fmt_reg == FS_VVAL) ? num_char(volt_reg, vdp_reg, idx_reg) :
            (field_num ? num_char(res_reg, rdp_reg, idx_reg) : txt[31 - 8 * idx_reg -: 8]);
        field_last = (idx_reg == (field_num ? VAL_LEN - 3'h1 : txt_len - 3'h1));
        if (fmt_reg == FS_IDLE)
        begin
            // Triggers in setup mode are ignored.
            if (trig_fall && !setup_mode_i)
            begin
                res_next = res_bcd_i;
                volt_next = volt_bcd_i;
                rdp_next = res_dp_i;
                vdp_next = volt_dp_i;
                jdg_next = judge_i;
                of_next = overflow_i;
                ng_next = abnormal_i;
                vm_next = volt_mode_i;
                ce_next = comp_enable_i;
                fmt_next = (abnormal_i || overflow_i) ? FS_MARK : FS_RVAL;
                idx_next = 3'h0;
            end
        end
        // Entering setup mode aborts the record.
        else if (setup_mode_i)
        begin
            fmt_next = FS_IDLE;
            idx_next = 3'h0;
        end
        else
        begin
            push_valid = 1'b1;
            if (push_ready)
            begin
                idx_next = field_last ? 3'h0 : idx_reg + 3'h1;
                if (field_last)
                begin
                    // Field order skips the judgement when off.
                    fmt_next = (fmt_reg == FS_RVAL) ? FS_UNIT :
                        ((fmt_reg == FS_UNIT && !vm_reg) ? (ce_reg ? FS_JSEP : FS_EOL) :
                        after_field(fmt_reg, vm_reg, ce_reg));
                end
            end
        end
    end

    // Formatter registers.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fmt_reg <= FS_IDLE;
            idx_reg <= 3'h0;
            res_reg <= 20'h0_0000;
            volt_reg <= 20'h0_0000;
            rdp_reg <= 3'h0;
            vdp_reg <= 3'h0;
            jdg_reg <= 3'h0;
            of_reg <= 1'b0;
            ng_reg <= 1'b0;
            vm_reg <= 1'b0;
            ce_reg <= 1'b0;
        end
        else
        begin
            fmt_reg <= fmt_next;
            idx_reg <= idx_next;
            res_reg <= res_next;
            volt_reg <= volt_next;
            rdp_reg <= rdp_next;
            vdp_reg <= vdp_next;
            jdg_reg <= jdg_next;
            of_reg <= of_next;
            ng_reg <= ng_next;
            vm_reg <= vm_next;
            ce_reg <= ce_next;
        end
    end

    // Two-entry buffer between formatter and printer handshake.
    mrpp_buf #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_data),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );

    // Printer handshake: busy low, data setup, strobe low pulse, hold.
    always_comb
    begin
        port_next = port_reg;
        cnt_next = (cnt_reg != 9'h000) ? cnt_reg - 9'h001 : 9'h000;
        data_next = data_reg;
        strobe_n_next = strobe_n_reg;
        // Take a byte only while busy is low.
        pop_ready = (port_reg == PS_IDLE) && !busy_level_reg;
        case (port_reg)
            PS_IDLE:
            begin
                if (pop_valid && !busy_level_reg)
                begin
                    data_next = pop_data;
                    cnt_next = SETUP_CYC - 9'h001;
                    port_next = PS_SETUP;
                end
            end
            PS_SETUP:
            begin
                if (cnt_reg == 9'h000)
                begin
                    strobe_n_next = 1'b0;
                    cnt_next = STROBE_CYC - 9'h001;
                    port_next = PS_STROBE;
                end
            end
            PS_STROBE:
            begin
                if (cnt_reg == 9'h000)
                begin
                    strobe_n_next = 1'b1;
                    cnt_next = HOLD_CYC - 9'h001;
                    port_next = PS_HOLD;
                end
            end
            PS_HOLD:
            begin
                if (cnt_reg == 9'h000)
                begin
                    port_next = PS_IDLE;
                end
            end
            default: port_next = PS_IDLE;
        endcase
        printing_next = (fmt_next != FS_IDLE) || (port_next != PS_IDLE) || pop_valid;
    end

    // Handshake registers; every output comes from here.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            port_reg <= PS_IDLE;
            cnt_reg <= 9'h000;
            data_reg <= 8'h00;
            strobe_n_reg <= 1'b1;
            printing_reg <= 1'b0;
        end
        else
        begin
            port_reg <= port_next;
            cnt_reg <= cnt_next;
            data_reg <= data_next;
            strobe_n_reg <= strobe_n_next;
            printing_reg <= printing_next;
        end
    end

    assign data_o = data_reg;
    assign strobe_n_o = strobe_n_reg;
    assign printing_o = printing_reg;

endmodule // mrpp_top

`default_nettype wire

// file: sim/mrpp_printer_model.sv
/*
 * Behavioural text printer on the parallel port: latches a byte on each strobe
 * fall and answers with busy for a commanded number of cycles.
 * Assumes the same clock as the port logic.
 */
`timescale 1ns/10ps
`default_nettype none

module mrpp_printer_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] data_i,
    input wire logic strobe_n_i,
    input wire logic [15:0] delay_i,
    output logic busy_o,
    output logic [7:0] byte_o,
    output logic got_o
);
    logic strobe_q;
    logic [15:0] cnt;

    // Strobe edge detection, byte capture and busy timing.
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_q <= 1'b1;
            busy_o <= 1'b0;
            byte_o <= 8'h00;
            got_o <= 1'b0;
            cnt <= 16'h0000;
        end
        else
        begin
            strobe_q <= strobe_n_i;
            got_o <= 1'b0;
            if (strobe_q && !strobe_n_i)
            begin
                byte_o <= data_i;
                got_o <= 1'b1;
            end
            if (!strobe_q && strobe_n_i && delay_i != 16'h0000)
            begin
                busy_o <= 1'b1;
                cnt <= delay_i;
            end
            else if (cnt != 16'h0000)
                cnt <= cnt - 16'h0001;
            else
                busy_o <= 1'b0;
        end
    end
endmodule // mrpp_printer_model
`default_nettype wire

// file: sim/mrpp_top_assertions.sv
/*
 * Checker for the printer port: strobe width, data setup and hold, busy stall,
 * trigger response, setup-mode silence and printable bytes.
 * Assumes it is bound to mrpp_top and sees only that module's ports.
 */
`timescale 1ns/10ps
`default_nettype none

module mrpp_chk
    import mrpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic print_trig_n_i,
    input wire logic busy_i,
    input wire logic setup_mode_i,
    input wire logic [7:0] data_o,
    input wire logic strobe_n_o,
    input wire logic printing_o
);
    // Cycles of strobe low, strobe high and data age; the last two saturate.
    logic [8:0] low_reg, low_next, high_reg, high_next, age_reg, age_next;
    logic [7:0] prev_reg;

    // Next counter values.
    always_comb
    begin
        low_next = strobe_n_o ? 9'h000 : low_reg + 9'h001;
        high_next = !strobe_n_o ? 9'h000 : ((&high_reg) ? high_reg : high_reg + 9'h001);
        age_next = (data_o != prev_reg) ? 9'h000 : ((&age_reg) ? age_reg : age_reg + 9'h001);
    end

    // Counter registers; idle counts start saturated so the first byte is legal.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_reg <= 9'h000;
            high_reg <= 9'h1FF;
            age_reg <= 9'h1FF;
            prev_reg <= 8'h00;
        end
        else
        begin
            low_reg <= low_next;
            high_reg <= high_next;
            age_reg <= age_next;
            prev_reg <= data_o;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // A clean falling trigger while idle and measuring.
    sequence s_trig_req;
        !printing_o && !setup_mode_i && $fell(print_trig_n_i) ##1 (!print_trig_n_i && !setup_mode_i) [*6];
    endsequence

    property p_trig_start;
        s_trig_req |-> ##[0:4] printing_o;
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("record did not start after a trigger");

    property p_trig_cause;
        $rose(printing_o) |-> $past(print_trig_n_i, 4) == 1'b0;
    endproperty
    a_trig_cause: assert property (p_trig_cause)
        else $error("record started without a trigger");

    property p_setup_quiet;
        setup_mode_i [*6] |=> !$rose(printing_o);
    endproperty
    a_setup_quiet: assert property (p_setup_quiet)
        else $error("record started in setup mode");

    property p_printable;
        $fell(strobe_n_o) |-> (data_o inside {[8'h20:8'h7E], 8'h0D, 8'h0A});
    endproperty
    a_printable: assert property (p_printable)
        else $error("byte is not printable text");

    property p_strobe_width;
        $rose(strobe_n_o) |-> low_reg == STROBE_CYC;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe pulse width wrong");

    property p_data_steady;
        !strobe_n_o |-> $stable(data_o);
    endproperty
    a_data_steady: assert property (p_data_steady)
        else $error("data moved during strobe");

    property p_setup_time;
        $fell(strobe_n_o) |-> age_reg >= SETUP_CYC - 9'h001;
    endproperty
    a_setup_time: assert property (p_setup_time)
        else $error("data setup before strobe too short");

    property p_hold_time;
        (data_o != prev_reg) |-> strobe_n_o && high_reg >= HOLD_CYC - 9'h001;
    endproperty
    a_hold_time: assert property (p_hold_time)
        else $error("data changed inside hold time");

    property p_busy_stall;
        busy_i [*6] |=> $stable(data_o);
    endproperty
    a_busy_stall: assert property (p_busy_stall)
        else $error("byte loaded while printer busy");

    property p_idle_port;
        !printing_o |-> strobe_n_o;
    endproperty
    a_idle_port: assert property (p_idle_port)
        else $error("strobe low outside a record");
endmodule // mrpp_chk

bind mrpp_top mrpp_chk u_mrpp_chk (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .print_trig_n_i(print_trig_n_i),
    .busy_i(busy_i),
    .setup_mode_i(setup_mode_i),
    .data_o(data_o),
    .strobe_n_o(strobe_n_o),
    .printing_o(printing_o)
);
`default_nettype wire

// file: sim/tb_mrpp_top.sv
/*
 * Self-checking bench: a byte-queue model of each record is compared with
 * every byte the printer model latches.
 * Assumes a 250 MHz clock and the printer model on the far side.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_mrpp_top;
    import mrpp_pkg::*;
    logic clk_i, arst_n_i, print_trig_n_i, busy_i, setup_mode_i, comp_enable_i;
    logic volt_mode_i, overflow_i, abnormal_i, strobe_n_o, printing_o, got;
    logic [19:0] res_bcd_i, volt_bcd_i;
    logic [2:0] res_dp_i, volt_dp_i, judge_i;
    logic [7:0] data_o, rx_byte;
    logic [15:0] delay;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int bad_count, compares;

    mrpp_top u_mrpp_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .print_trig_n_i(print_trig_n_i),
        .busy_i(busy_i), .setup_mode_i(setup_mode_i), .comp_enable_i(comp_enable_i),
        .volt_mode_i(volt_mode_i), .overflow_i(overflow_i), .abnormal_i(abnormal_i),
        .res_bcd_i(res_bcd_i), .res_dp_i(res_dp_i), .volt_bcd_i(volt_bcd_i), .volt_dp_i(volt_dp_i),
        .judge_i(judge_i), .data_o(data_o), .strobe_n_o(strobe_n_o), .printing_o(printing_o));

    mrpp_printer_model u_mrpp_printer_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .data_i(data_o),
        .strobe_n_i(strobe_n_o), .delay_i(delay), .busy_o(busy_i), .byte_o(rx_byte), .got_o(got));

    // Xorshift source with a fixed start.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Five random decimal digits.
    function automatic logic [19:0] bcd(input logic [31:0] r);
        logic [19:0] b;
        for (int k = 0; k < 5; k++)
            b[4*k +: 4] = 4'((r >> (6 * k)) % 32'h0000_000A);
        return b;
    endfunction

    task automatic check8(input logic [7:0] e, input logic [7:0] a);
        compares++;
        if (a !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic check1(input logic e, input logic a);
        compares++;
        if (a !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic push_s(input string s);
        foreach (s[i])
            exp_q.push_back(s[i]);
    endtask

    // Five digits with the point after dp of them.
    task automatic push_val(input logic [19:0] b, input logic [2:0] dp);
        for (int i = 0; i < 6; i++)
        begin
            if (i == int'(dp))
                exp_q.push_back(8'h2E);
            if (i < 5)
                exp_q.push_back(8'h30 + {4'h0, b[19 - 4 * i -: 4]});
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic results();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One trigger with the given settings; the model queue is built first.
    task automatic record(input logic setup, comp, volt, ovf, abn, input logic [2:0] jdg,
        input logic [15:0] dly);
        logic [19:0] rb, vb;
        logic [2:0] rd, vd;
        int n;
        rb = bcd(rnd());
        vb = bcd(rnd());
        rd = 3'(rnd() % 32'h0000_0006);
        vd = 3'(rnd() % 32'h0000_0006);
        @(posedge clk_i);
        {setup_mode_i, comp_enable_i, volt_mode_i, overflow_i, abnormal_i} <= {setup, comp, volt, ovf, abn};
        {res_bcd_i, res_dp_i, volt_bcd_i, volt_dp_i, judge_i, delay} <= {rb, rd, vb, vd, jdg, dly};
        if (!setup)
        begin
            if (abn)
                push_s("NG");
            else if (ovf)
                push_s("OF");
            else
            begin
                push_val(rb, rd);
                push_s(" ohm");
            end
            if (volt)
            begin
                push_s(", ");
                push_val(vb, vd);
                push_s("V");
            end
            if (comp)
            begin
                push_s(",");
                case (jdg)
                    3'h0: push_s("Pass");
                    3'h1: push_s("Fail");
                    3'h2: push_s("Lo");
                    3'h3: push_s("IN");
                    default: push_s("Hi");
                endcase
            end
            exp_q.push_back(8'h0D);
            exp_q.push_back(8'h0A);
        end
        print_trig_n_i <= 1'b0;
        tick(20);
        print_trig_n_i <= 1'b1;
        check1(!setup, printing_o);
        n = 0;
        while (printing_o !== 1'b0 && n < 40000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40000)
        begin
            bad_count++;
            results();
        end
        tick(100);
        check1(1'b1, exp_q.size() == 0);
    endtask

    // Each latched byte is compared with the model's next byte.
    always @(posedge clk_i)
    begin
        if (got)
        begin
            if (exp_q.size() == 0)
                check1(1'b0, 1'b1);
            else
                check8(exp_q.pop_front(), rx_byte);
        end
    end

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Main sequence.
    initial
    begin
        seed = 32'h0000_BA32;
        bad_count = 0;
        compares = 0;
        {arst_n_i, print_trig_n_i, setup_mode_i, comp_enable_i, volt_mode_i} = 5'b01000;
        {overflow_i, abnormal_i, res_bcd_i, res_dp_i, volt_bcd_i, volt_dp_i, judge_i} = '0;
        delay = 16'h0000;
        tick(6);
        arst_n_i <= 1'b1;
        tick(5);
        record(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0010);
        record(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 16'(rnd() & 32'h0000_003F));
        for (int j = 0; j < 5; j++)
            record(1'b0, 1'b1, j == 0, 1'b0, 1'b0, 3'(j), j == 1 ? 16'h02BC : 16'(rnd() & 32'h0000_003F));
        record(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 16'h0020);
        record(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 16'h0008);
        results();
    end
endmodule // tb_mrpp_top
`default_nettype wire
